/* arf_pkg.sv */
// package: register map, field layout, reset values and timing constants
package arf_pkg;

    // register byte addresses
    localparam logic [31:0] STATUS_OFS  = 32'h40030000;
    localparam logic [31:0] PCFG_OFS    = 32'h40030008;
    localparam logic [31:0] SCFG_OFS    = 32'h4003000C;
    localparam logic [31:0] CTRL_OFS    = 32'h40030010;
    localparam logic [31:0] LIMIT_OFS   = 32'h40030014;
    localparam logic [31:0] COUNT_OFS   = 32'h40030018;
    localparam logic [31:0] RESULT_OFS  = 32'h40030020;

    // control register fields
    localparam int CTRL_RCEN_BIT = 0;
    localparam int CTRL_FAST_BIT = 1;
    localparam int CTRL_ACC_BIT  = 2;
    localparam int CTRL_W        = 3;

    // primary configuration fields
    localparam int PCFG_GAIN_LSB = 0;
    localparam int GAIN_W        = 4;
    localparam int PCFG_CODE_BIT = 4;
    localparam int PCFG_W        = 5;
    localparam logic [3:0] GAIN_MAX = 4'h9;

    // secondary configuration fields
    localparam int SCFG_CH_LSB = 0;
    localparam int CH_W        = 4;
    localparam logic [3:0] TEMP_CHANNEL = 4'hF;

    // status register fields
    localparam int STAT_RDY_BIT  = 0;
    localparam int STAT_TEMP_BIT = 1;
    localparam int STAT_PEND_BIT = 2;

    // widths and reset values
    localparam int CNT_W      = 16;
    localparam int SAMPLE_W   = 28;
    localparam logic [31:0] RESULT_RST = 32'h00000001;
    localparam logic [31:0] REG_RST    = 32'h00000000;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // fast temperature conversion time
    localparam int TEMP_TIME_US = 1000;
    localparam int CLK_MHZ      = 25;
    localparam int TEMP_CYCLES  = TEMP_TIME_US * CLK_MHZ;

    // fast conversion sequencer states
    typedef enum logic [1:0] {
        FAST_IDLE = 2'b00,
        FAST_PEND = 2'b01,
        FAST_TEMP = 2'b10
    } arf_fast_t;

endpackage : arf_pkg

/* arf_top.sv */
// converter result handling, result counter and fast temperature request
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// What this block does
// - fast conversion only on request bit rising
// - finish one configured conversion, then switch
// - return to configured channel after fast conversion
// - fast conversion lasts a fixed one millisecond
// - counter off: held zero, interrupt every conversion
// - counter on: interrupt when count equals limit
// - intermediate results dropped unless accumulating
// - result register 32 bits, resets to one
// - result aligned to gain, no software scaling
// - twos complement or unipolar per coding bit
// - gain 512 signal in bits 18 to 1
// - bit zero high means result invalid
// - ready flag set blocks result update
// - core off: no blocking, latest result kept
// - counter on: update only at limit
// - ready set together with result write
////////////////////////////////////////////////////////////////////////////
module arf_top #(
    parameter int TEMP_CYCLES = arf_pkg::TEMP_CYCLES
) (
    input  wire logic        aclk,          // system clock, 25 MHz
    input  wire logic        aresetn,       // synchronous reset, low
    input  wire logic [31:0] s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [31:0] s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready,  // read data ready
    input  wire logic        conv_done,     // primary conversion pulse
    input  wire logic [27:0] conv_sample,   // primary raw sample
    input  wire logic        conv_settled,  // sample is settled
    input  wire logic        sec_conv_done, // secondary conversion pulse
    input  wire logic        core_off,      // processor core powered off
    output logic             conv_irq,      // converter interrupt pulse
    output logic [3:0]       sec_channel,   // secondary channel select
    output logic             sec_temp_conv  // fixed-time temp conversion
);

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // sign-extend a raw sample to a word
    function automatic logic [31:0] sext(input logic [27:0] s);
        sext = {{(32 - arf_pkg::SAMPLE_W){s[27]}}, s};
    endfunction : sext

    // align to gain, apply coding and validity flag
    function automatic logic [31:0] fmt_result(input logic [31:0] v,
                                               input logic [3:0]  gc,
                                               input logic        unip,
                                               input logic        bad);
        logic [31:0] r;
        logic [3:0]  g;
        g = (gc > arf_pkg::GAIN_MAX) ? arf_pkg::GAIN_MAX : gc;
        r = $signed(v) >>> g;
        if (unip) begin
            r = r ^ (32'h08000000 >> g);
            r = r & (32'h0FFFFFFF >> g);
        end
        r[0] = bad;
        fmt_result = r;
    endfunction : fmt_result

    // merge write data into a register under byte enables
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        wmerge = r;
    endfunction : wmerge

    ////////////////////////////////////////////////////////////////////////
    // state declarations
    logic [31:0]             aw_addr_reg;
    logic [31:0]             w_data_reg;
    logic [3:0]              w_strb_reg;
    logic [arf_pkg::CTRL_W-1:0] ctrl_reg;
    logic [arf_pkg::PCFG_W-1:0] pcfg_reg;
    logic [arf_pkg::CH_W-1:0]   scfg_reg;
    logic [arf_pkg::CNT_W-1:0]  limit_reg;
    logic [arf_pkg::CNT_W-1:0]  count_reg;
    logic [31:0]             acc_reg;
    logic [31:0]             result_reg;
    logic                    ready_reg;
    logic                    fast_prev_reg;
    arf_pkg::arf_fast_t      fast_reg;
    logic [15:0]             temp_timer_reg;
    logic                    wr_go;
    logic                    rd_take;
    logic                    rd_clr;
    logic                    rc_en;
    logic                    acc_en;
    logic                    hit;
    logic                    upd;
    logic                    fast_rise;
    logic                    temp_end;
    logic [31:0]             sum;
    logic [31:0]             rd_mux;
    logic                    rd_ok;
    logic [31:0]             ctrl_wm;
    logic [31:0]             pcfg_wm;
    logic [31:0]             scfg_wm;
    logic [31:0]             limit_wm;

    ////////////////////////////////////////////////////////////////////////
    // decode of bus handshakes and conversion events
    assign rc_en     = ctrl_reg[arf_pkg::CTRL_RCEN_BIT];
    assign acc_en    = ctrl_reg[arf_pkg::CTRL_ACC_BIT];
    assign wr_go     = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign rd_take   = s_axi_arvalid && s_axi_arready;
    assign rd_clr    = rd_take && (s_axi_araddr == arf_pkg::RESULT_OFS);
    assign hit       = conv_done && (!rc_en || count_reg == limit_reg);
    assign upd       = hit && (!ready_reg || core_off);
    assign sum       = (rc_en && acc_en) ? acc_reg + sext(conv_sample)
                                         : sext(conv_sample);
    assign fast_rise = ctrl_reg[arf_pkg::CTRL_FAST_BIT] && !fast_prev_reg;
    // merged write words, one per writable register
    assign ctrl_wm   = wmerge(32'(ctrl_reg), w_data_reg, w_strb_reg);
    assign pcfg_wm   = wmerge(32'(pcfg_reg), w_data_reg, w_strb_reg);
    assign scfg_wm   = wmerge(32'(scfg_reg), w_data_reg, w_strb_reg);
    assign limit_wm  = wmerge(32'(limit_reg), w_data_reg, w_strb_reg);
    assign temp_end  = (fast_reg == arf_pkg::FAST_TEMP) &&
                       (temp_timer_reg == 16'(TEMP_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= arf_pkg::RESP_OKAY;
            aw_addr_reg   <= arf_pkg::REG_RST;
            w_data_reg    <= arf_pkg::REG_RST;
            w_strb_reg    <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid  <= 1'b1;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                case (aw_addr_reg)
                    arf_pkg::STATUS_OFS, arf_pkg::PCFG_OFS,
                    arf_pkg::SCFG_OFS,   arf_pkg::CTRL_OFS,
                    arf_pkg::LIMIT_OFS,  arf_pkg::COUNT_OFS,
                    arf_pkg::RESULT_OFS: s_axi_bresp <= arf_pkg::RESP_OKAY;
                    default:             s_axi_bresp <= arf_pkg::RESP_DECERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software-written configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg  <= '0;
            pcfg_reg  <= '0;
            scfg_reg  <= '0;
            limit_reg <= '0;
        end else if (wr_go) begin
            case (aw_addr_reg)
                arf_pkg::CTRL_OFS:  ctrl_reg  <= ctrl_wm[arf_pkg::CTRL_W-1:0];
                arf_pkg::PCFG_OFS:  pcfg_reg  <= pcfg_wm[arf_pkg::PCFG_W-1:0];
                arf_pkg::SCFG_OFS:  scfg_reg  <= scfg_wm[arf_pkg::CH_W-1:0];
                arf_pkg::LIMIT_OFS: limit_reg <= limit_wm[arf_pkg::CNT_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel: one-cycle answer, result read clears ready flag
    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            arf_pkg::STATUS_OFS: begin
                rd_mux[arf_pkg::STAT_RDY_BIT]  = ready_reg;
                rd_mux[arf_pkg::STAT_TEMP_BIT] =
                    (fast_reg == arf_pkg::FAST_TEMP);
                rd_mux[arf_pkg::STAT_PEND_BIT] =
                    (fast_reg == arf_pkg::FAST_PEND);
            end
            arf_pkg::PCFG_OFS:   rd_mux = 32'(pcfg_reg);
            arf_pkg::SCFG_OFS:   rd_mux = 32'(scfg_reg);
            arf_pkg::CTRL_OFS:   rd_mux = 32'(ctrl_reg);
            arf_pkg::LIMIT_OFS:  rd_mux = 32'(limit_reg);
            arf_pkg::COUNT_OFS:  rd_mux = 32'(count_reg);
            arf_pkg::RESULT_OFS: rd_mux = result_reg;
            default:             rd_ok  = 1'b0;
        endcase
    end

    // read handshake registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= arf_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_ok ? arf_pkg::RESP_OKAY
                                   : arf_pkg::RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result counter and accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn || !rc_en) begin
            count_reg <= '0;
            acc_reg   <= 32'h00000000;
        end else if (conv_done) begin
            if (hit) begin
                count_reg <= '0;
                acc_reg   <= 32'h00000000;
            end else begin
                count_reg <= count_reg + 1'b1;
                if (acc_en) begin
                    acc_reg <= sum;
                end
            end
        end
    end

    // primary result register, written while ready is clear or core off, at counter limit or at every conversion with counter off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_reg <= arf_pkg::RESULT_RST;
        end else if (upd) begin
            result_reg <= fmt_result(sum,
                pcfg_reg[arf_pkg::PCFG_GAIN_LSB +: arf_pkg::GAIN_W],
                pcfg_reg[arf_pkg::PCFG_CODE_BIT], !conv_settled);
        end
    end

    // ready flag: set on result event wins over read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_reg <= 1'b0;
        end else if (hit) begin
            ready_reg <= 1'b1;
        end else if (rd_clr) begin
            ready_reg <= 1'b0;
        end
    end

    // interrupt pulse once per counted result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_irq <= 1'b0;
        end else begin
            conv_irq <= hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fast temperature sequencer on the secondary converter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_prev_reg  <= 1'b0;
            fast_reg       <= arf_pkg::FAST_IDLE;
            temp_timer_reg <= 16'h0000;
        end else begin
            fast_prev_reg <= ctrl_reg[arf_pkg::CTRL_FAST_BIT];
            case (fast_reg)
                arf_pkg::FAST_IDLE: begin
                    if (fast_rise) begin
                        fast_reg <= arf_pkg::FAST_PEND;
                    end
                end
                arf_pkg::FAST_PEND: begin
                    if (sec_conv_done) begin
                        fast_reg       <= arf_pkg::FAST_TEMP;
                        temp_timer_reg <= 16'h0000;
                    end
                end
                arf_pkg::FAST_TEMP: begin
                    if (temp_end) begin
                        fast_reg <= arf_pkg::FAST_IDLE;
                    end else begin
                        temp_timer_reg <= temp_timer_reg + 16'h0001;
                    end
                end
                default: fast_reg <= arf_pkg::FAST_IDLE;
            endcase
        end
    end

    // secondary channel select and fixed-time mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_channel   <= 4'h0;
            sec_temp_conv <= 1'b0;
        end else if (fast_reg == arf_pkg::FAST_PEND && sec_conv_done) begin
            sec_channel   <= arf_pkg::TEMP_CHANNEL;
            sec_temp_conv <= 1'b1;
        end else if (fast_reg != arf_pkg::FAST_TEMP || temp_end) begin
            sec_channel   <= scfg_reg;
            sec_temp_conv <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_fast_edge;
        @(posedge aclk) disable iff (!aresetn)
        fast_rise && fast_reg == arf_pkg::FAST_IDLE
            |=> fast_reg == arf_pkg::FAST_PEND;
    endproperty
    a_fast_edge: assert property (p_fast_edge)
        else $error("fast request edge not taken");

    property p_fast_hold;
        @(posedge aclk) disable iff (!aresetn)
        fast_reg == arf_pkg::FAST_IDLE && !fast_rise
            |=> fast_reg == arf_pkg::FAST_IDLE;
    endproperty
    a_fast_hold: assert property (p_fast_hold)
        else $error("fast conversion without rising request");

    property p_pend_switch;
        @(posedge aclk) disable iff (!aresetn)
        fast_reg == arf_pkg::FAST_PEND && sec_conv_done
            |=> sec_temp_conv && sec_channel == arf_pkg::TEMP_CHANNEL;
    endproperty
    a_pend_switch: assert property (p_pend_switch)
        else $error("no switch to temperature after pending conversion");

    property p_return;
        @(posedge aclk) disable iff (!aresetn)
        temp_end |=> !sec_temp_conv ##1 sec_channel == $past(scfg_reg);
    endproperty
    a_return: assert property (p_return)
        else $error("secondary channel not restored");

    property p_temp_len;
        @(posedge aclk) disable iff (!aresetn)
        $fell(sec_temp_conv) |-> $past(temp_timer_reg) ==
            16'(TEMP_CYCLES - 1);
    endproperty
    a_temp_len: assert property (p_temp_len)
        else $error("temperature conversion length wrong");

    property p_cnt_off;
        @(posedge aclk) disable iff (!aresetn)
        !rc_en |=> count_reg == '0;
    endproperty
    a_cnt_off: assert property (p_cnt_off)
        else $error("result counter not held at zero");

    property p_irq_each;
        @(posedge aclk) disable iff (!aresetn)
        conv_done && !rc_en |=> conv_irq ##1 (!conv_irq || $past(conv_done));
    endproperty
    a_irq_each: assert property (p_irq_each)
        else $error("missing interrupt with counter off");

    property p_irq_limit;
        @(posedge aclk) disable iff (!aresetn)
        rc_en && !(conv_done && count_reg == limit_reg) |=> !conv_irq;
    endproperty
    a_irq_limit: assert property (p_irq_limit)
        else $error("interrupt before counter limit");

    property p_block;
        @(posedge aclk) disable iff (!aresetn)
        ready_reg && !core_off |=> $stable(result_reg);
    endproperty
    a_block: assert property (p_block)
        else $error("result overwritten while ready set");

    property p_ready_set;
        @(posedge aclk) disable iff (!aresetn)
        upd |=> ready_reg && result_reg[0] == !$past(conv_settled);
    endproperty
    a_ready_set: assert property (p_ready_set)
        else $error("ready flag not set with result write");

    c_fast_done:  cover property (@(posedge aclk) disable iff (!aresetn)
        temp_end);
    c_limit_irq:  cover property (@(posedge aclk) disable iff (!aresetn)
        rc_en && hit);
    c_blocked:    cover property (@(posedge aclk) disable iff (!aresetn)
        hit && ready_reg && !core_off);
    c_core_off:   cover property (@(posedge aclk) disable iff (!aresetn)
        hit && ready_reg && core_off);

endmodule : arf_top

/* tb_adc_result_count_fast_temp.sv */
// testbench: register bus, result format, result counter, fast temperature
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_adc_result_count_fast_temp;
    localparam int TC = 20;
    logic        aclk = 0, aresetn = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, conv_irq, sec_temp_conv;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_q;
    logic [31:0] s_axi_rdata;
    logic [3:0]  sec_channel;
    logic        conv_done = 0, conv_settled = 0, sec_conv_done = 0;
    logic        core_off = 0;
    logic [27:0] conv_sample = 0;
    logic [31:0] seed = 32'hDDC5;
    int          fail_count = 0, n_tests = 0, irq_cnt = 0;
    ////////////////////////////////////////////////////////////////////////
    arf_top #(.TEMP_CYCLES(TC)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .conv_done(conv_done), .conv_sample(conv_sample),
        .conv_settled(conv_settled), .sec_conv_done(sec_conv_done),
        .core_off(core_off), .conv_irq(conv_irq), .sec_channel(sec_channel),
        .sec_temp_conv(sec_temp_conv)
    );
    // clock and interrupt pulse counter
    always #20 aclk = ~aclk;
    always @(posedge aclk) if (conv_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    ////////////////////////////////////////////////////////////////////////
    // xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // expected gain-aligned result word
    function automatic logic [31:0] exp_res(logic [27:0] s, logic [3:0] g,
                                            logic u, logic st);
        logic [31:0] v;
        v = $signed({{4{s[27]}}, s}) >>> g;
        if (u) begin
            v[27-g] = ~v[27-g];
            v = v & ((32'h1 << (28 - g)) - 32'h1);
        end
        v[0] = ~st;
        return v;
    endfunction : exp_res
    // bus write: address and data offered together
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        bresp_q = s_axi_bresp;
        s_axi_bready <= 0;
        @(posedge aclk);
    endtask : wr
    // bus read: data and response taken at the rvalid edge
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        @(posedge aclk);
    endtask : rd
    // one primary conversion pulse, then two idle cycles
    task automatic conv(input logic [27:0] s, input logic st);
        conv_done <= 1; conv_sample <= s; conv_settled <= st;
        @(posedge aclk);
        conv_done <= 0;
        repeat (2) @(posedge aclk);
    endtask : conv
    // one secondary conversion pulse
    task automatic sec();
        sec_conv_done <= 1;
        @(posedge aclk);
        sec_conv_done <= 0;
    endtask : sec
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        end_of_test();
    end
    // main sequence
    initial begin
        logic [31:0] d; logic [1:0] r; logic [27:0] s; logic [3:0] g;
        logic u, st; int k, irqs;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(arf_pkg::RESULT_OFS, d, r); `CHK(d, arf_pkg::RESULT_RST)
        rd(32'h40030040, d, r);
        `CHK(r, arf_pkg::RESP_DECERR)
        `CHK(d, 32'h0)
        wr(32'h40030040, 32'h0); `CHK(bresp_q, arf_pkg::RESP_DECERR)
        // gain codes 0 to 9 in both codings, counter off
        for (k = 0; k < 20; k++) begin
            g = k[4:1]; u = k[0]; d = rnd(); s = d[27:0]; st = d[31];
            irqs = irq_cnt;
            wr(arf_pkg::PCFG_OFS, {27'h0, u, g});
            conv(s, st);
            rd(arf_pkg::RESULT_OFS, d, r);
            `CHK(d, exp_res(s, g, u, st))
            `CHK(irq_cnt, irqs + 1)
        end
        // ready flag blocks, core off does not
        d = rnd(); s = d[27:0];
        conv(s, 1); conv(~s, 1);
        rd(arf_pkg::RESULT_OFS, d, r); `CHK(d, exp_res(s, g, u, 1))
        conv(s, 1); core_off <= 1; conv(~s, 1); core_off <= 0;
        rd(arf_pkg::RESULT_OFS, d, r); `CHK(d, exp_res(~s, g, u, 1))
        // result counter with limit 3
        wr(arf_pkg::LIMIT_OFS, 32'h3); wr(arf_pkg::CTRL_OFS, 32'h1);
        irqs = irq_cnt; d = rnd(); s = d[27:0];
        conv(~s, 1); conv(s ^ 28'h5A5, 1);
        rd(arf_pkg::COUNT_OFS, d, r); `CHK(d, 32'h2)
        `CHK(irq_cnt, irqs)
        conv(~s, 1); conv(s, 1);
        rd(arf_pkg::RESULT_OFS, d, r); `CHK(d, exp_res(s, g, u, 1))
        `CHK(irq_cnt, irqs + 1)
        rd(arf_pkg::COUNT_OFS, d, r); `CHK(d, 32'h0)
        // accumulator on: four samples summed into one result
        wr(arf_pkg::CTRL_OFS, 32'h5);
        s = 28'h0;
        for (k = 0; k < 4; k++) begin
            d = rnd(); d[27:0] = {{4{d[23]}}, d[23:0]}; s = s + d[27:0];
            conv(d[27:0], 1);
        end
        rd(arf_pkg::RESULT_OFS, d, r); `CHK(d, exp_res(s, g, u, 1))
        // fast temperature request, after interrupts have occurred
        wr(arf_pkg::SCFG_OFS, 32'h5); `CHK(bresp_q, arf_pkg::RESP_OKAY)
        wr(arf_pkg::CTRL_OFS, 32'h2);
        repeat (4) @(posedge aclk);
        `CHK(sec_temp_conv, 1'b0)
        `CHK(sec_channel, 4'h5)
        sec();
        k = 0;
        while (sec_temp_conv !== 1'b1 && k < 5) begin @(posedge aclk); k++; end
        `CHK(sec_channel, arf_pkg::TEMP_CHANNEL)
        k = 0;
        while (sec_temp_conv === 1'b1 && k < 2 * TC) begin
            @(posedge aclk); k++;
        end
        `CHK(k, TC)
        `CHK(sec_channel, 4'h5)
        sec(); repeat (4) @(posedge aclk);
        `CHK(sec_temp_conv, 1'b0)
        // clear the request, then a fresh rising edge runs once more
        wr(arf_pkg::CTRL_OFS, 32'h0);
        wr(arf_pkg::CTRL_OFS, 32'h2); sec();
        k = 0;
        while (sec_temp_conv !== 1'b1 && k < 5) begin @(posedge aclk); k++; end
        `CHK(sec_temp_conv, 1'b1)
        end_of_test();
    end
endmodule : tb_adc_result_count_fast_temp
